// ### verilog/pdcl_phase_ctrl.sv
`timescale 1ns/10ps
module pdcl_phase_ctrl
    import pdcl_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_enable,
    input  wire logic [4:2]       i_sense_high,
    input  wire logic [3:0]       i_pwm_cmp,
    input  wire logic             i_limit_over_norm,
    input  wire logic             i_limit_over_high,
    input  wire logic             i_ramp_uv,
    input  wire logic [ADC_W-1:0] i_current_max_strap_pin_adc,
    input  wire logic [ADC_W-1:0] i_imon_adc,
    input  wire logic [ADC_W-1:0] i_temp_adc,
    input  wire logic [3:0]       i_addr_strap,
    input  wire pdcl_rd_t         i_reg_rd,
    output logic [7:0]            o_reg_data,
    output logic [4:2]            o_test_sink_en,
    output pdcl_pwm_t             o_pwm,
    output logic [1:0]            o_ramp_phase_sel,
    output logic [1:0]            o_ramp_step,
    output logic                  o_ramp_sense_en,
    output logic                  o_driver_on,
    output logic                  o_fault,
    output logic [2:0]            o_phase_count,
    output logic [3:0]            o_bus_addr
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [2:0] phases_from_straps(input logic [4:2] s);
        logic [2:0] n;
        n = PHASES_FOUR;
        if (s[4] && s[3] && s[2]) begin
            n = PHASES_ONE;
        end else if (s[4] && s[2]) begin
            n = PHASES_TWO;
        end else if (s[4]) begin
            n = PHASES_THREE;
        end
        return n;
    endfunction

    // Saturating scale of a converter code to 8 bits, full scale at 2 V.
    function automatic logic [7:0] adc_to_byte(input logic [ADC_W-1:0] a);
        logic [7:0] b;
        b = (a[ADC_W-1:ADC_W-2] != 2'h0) ? 8'hFF : a[ADC_W-3:ADC_W-10];
        return b;
    endfunction

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    pdcl_state_t      st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [2:0]       ph_r, ph_nxt;
    logic [3:0]       addr_r, addr_nxt;
    logic [7:0]       current_max_strap_pin_r, current_max_strap_pin_nxt;
    logic [7:0]       imon_r, imon_nxt;
    logic [7:0]       temp_r, temp_nxt;
    logic [3:0]       mid_r, mid_nxt;
    logic [3:0]       used;
    logic             trip;
    logic             uv_live;

    assign uv_live = i_enable && i_ramp_uv;

    pdcl_oc_timer u_oc (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_arm       (st_r == ST_RUN),
        .i_over_norm (i_limit_over_norm),
        .i_over_high (i_limit_over_high),
        .o_trip      (trip)
    );

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            used[i] = (3'(i) < ph_r);
        end
    end

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        ph_nxt   = ph_r;
        addr_nxt = addr_r;
        current_max_strap_pin_nxt = current_max_strap_pin_r;
        imon_nxt = imon_r;
        temp_nxt = temp_r;
        mid_nxt  = mid_r;
        case (st_r)
            ST_OFF: begin
                cnt_nxt = '0;
                mid_nxt = 4'hF;
                if (i_enable) begin
                    st_nxt = ST_DETECT;
                end
            end
            ST_DETECT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (!i_enable) begin
                    st_nxt = ST_OFF;
                end else if (cnt_r == CNT_W'(DETECT_CYCLES - 1)) begin
                    ph_nxt   = phases_from_straps(i_sense_high);
                    // Straps above the last valid code fold to the highest address.
                    addr_nxt = (i_addr_strap > ADDR_MAX_CODE) ? ADDR_MAX_CODE
                                                              : i_addr_strap;
                    current_max_strap_pin_nxt = adc_to_byte(i_current_max_strap_pin_adc);
                    st_nxt   = ST_MID;
                end
            end
            ST_MID: begin
                st_nxt = i_enable ? ST_RUN : ST_OFF;
            end
            ST_RUN: begin
                mid_nxt  = mid_r & ~i_pwm_cmp;
                imon_nxt = adc_to_byte(i_imon_adc);
                temp_nxt = adc_to_byte(i_temp_adc);
                if (!i_enable || uv_live) begin
                    st_nxt = ST_OFF;
                end else if (trip) begin
                    st_nxt = ST_LATCH;
                end
            end
            ST_LATCH: begin
                if (!i_enable) begin
                    st_nxt = ST_OFF;
                end
            end
            default: st_nxt = ST_OFF;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r   <= ST_OFF;
            cnt_r  <= '0;
            ph_r   <= PHASES_FOUR;
            addr_r <= '0;
            current_max_strap_pin_r <= '0;
            imon_r <= '0;
            temp_r <= '0;
            mid_r  <= 4'hF;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            ph_r   <= ph_nxt;
            addr_r <= addr_nxt;
            current_max_strap_pin_r <= current_max_strap_pin_nxt;
            imon_r <= imon_nxt;
            temp_r <= temp_nxt;
            mid_r  <= mid_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    pdcl_pwm_t  pwm_nxt;
    logic [7:0] rd_nxt;
    logic [4:2] sink_nxt;

    always_comb begin
        pwm_nxt  = '0;
        sink_nxt = '0;
        case (st_r)
            ST_DETECT: begin
                sink_nxt   = 3'h7;
                pwm_nxt.oe = 4'h1;
            end
            ST_MID: begin
                pwm_nxt.oe  = used;
                pwm_nxt.mid = used;
            end
            ST_RUN: begin
                // Each phase follows its own comparator, so overlap is allowed.
                pwm_nxt.oe  = used;
                pwm_nxt.out = i_pwm_cmp & used;
                pwm_nxt.mid = used & mid_r & ~i_pwm_cmp;
            end
            ST_LATCH: pwm_nxt.oe = used;
            default: pwm_nxt = '0;
        endcase
        case (i_reg_rd.addr)
            PLAT_CUR_MAX_OFFSET: rd_nxt = current_max_strap_pin_r;
            CURRENT_OFFSET:      rd_nxt = imon_r;
            TEMP_OFFSET:         rd_nxt = temp_r;
            ADDR_OFFSET:         rd_nxt = {4'h0, addr_r};
            STATUS_OFFSET:       rd_nxt = {3'h0, st_r == ST_LATCH, 1'b0, ph_r};
            default:             rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pwm          <= '0;
            o_test_sink_en <= '0;
            o_reg_data     <= '0;
            o_driver_on    <= 1'b0;
            o_fault        <= 1'b0;
        end else begin
            o_pwm          <= pwm_nxt;
            o_test_sink_en <= sink_nxt;
            o_reg_data     <= i_reg_rd.rd ? rd_nxt : o_reg_data;
            o_driver_on    <= (st_r == ST_RUN);
            o_fault        <= (st_r == ST_LATCH);
        end
    end

    // Ramp offset is the phase index times the period split by the active count.
    // One and four phases need distinct codes, so the count is taken minus one.
    assign o_ramp_phase_sel = 2'(ph_r - 3'h1);
    assign o_ramp_step      = o_ramp_phase_sel;
    assign o_ramp_sense_en  = i_enable;
    assign o_phase_count    = ph_r;
    assign o_bus_addr       = addr_r;

endmodule

// ### verilog/pdcl_pkg.sv
package pdcl_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ          = 125;
    localparam int DETECT_TIME_US   = 30;
    localparam int OC_QUAL_TIME_US  = 50;
    localparam int DETECT_CYCLES    = DETECT_TIME_US * CLK_MHZ;
    localparam int OC_QUAL_CYCLES   = OC_QUAL_TIME_US * CLK_MHZ;
    localparam int CNT_W            = 16;

    // ****************************************************************
    // Converter scaling and register map
    // ****************************************************************
    localparam int ADC_W                      = 10;
    localparam logic [7:0] PLAT_CUR_MAX_OFFSET = 8'h21;
    localparam logic [7:0] CURRENT_OFFSET      = 8'h15;
    localparam logic [7:0] TEMP_OFFSET         = 8'h17;
    localparam logic [7:0] ADDR_OFFSET         = 8'h40;
    localparam logic [7:0] STATUS_OFFSET       = 8'h41;
    localparam logic [3:0] ADDR_MAX_CODE       = 4'h8;
    localparam logic [2:0] PHASES_FOUR         = 3'h4;
    localparam logic [2:0] PHASES_THREE        = 3'h3;
    localparam logic [2:0] PHASES_TWO          = 3'h2;
    localparam logic [2:0] PHASES_ONE          = 3'h1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_DETECT = 3'h1,
        ST_MID    = 3'h2,
        ST_RUN    = 3'h3,
        ST_LATCH  = 3'h4
    } pdcl_state_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
        logic [3:0] mid;
    } pdcl_pwm_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
    } pdcl_rd_t;

endpackage

// ### verilog/pdcl_oc_timer.sv
`timescale 1ns/10ps
module pdcl_oc_timer
    import pdcl_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_arm,
    input  wire logic i_over_norm,
    input  wire logic i_over_high,
    output logic      o_trip
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             trip_nxt;

    always_comb begin
        cnt_nxt  = '0;
        trip_nxt = 1'b0;
        if (i_arm && i_over_high) begin
            trip_nxt = 1'b1;
        end else if (i_arm && i_over_norm) begin
            if (cnt_r == CNT_W'(OC_QUAL_CYCLES - 1)) begin
                trip_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
        // Dropping below threshold leaves the count at zero.
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r  <= '0;
            o_trip <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            o_trip <= trip_nxt;
        end
    end

endmodule

// ### test/pdcl_chk_props.sv
`timescale 1ns/10ps
module pdcl_chk
    import pdcl_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_enable,
    input wire logic       i_limit_over_norm,
    input wire logic       i_limit_over_high,
    input wire logic [4:2] o_test_sink_en,
    input wire pdcl_pwm_t  o_pwm,
    input wire logic [1:0] o_ramp_step,
    input wire logic       o_ramp_sense_en,
    input wire logic       o_driver_on,
    input wire logic       o_fault,
    input wire logic [2:0] o_phase_count,
    input wire logic [3:0] o_bus_addr
);
    // ****************************************************************
    // Overcurrent run length
    // ****************************************************************
    logic [15:0] run_r;
    logic [15:0] run_nxt;
    always_comb begin
        run_nxt = (i_limit_over_norm && i_enable) ? run_r + 16'h1 : 16'h0;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_r <= 16'h0;
        end else begin
            run_r <= run_nxt;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_detect_low: assert property (o_test_sink_en != 3'h0 |-> o_pwm.oe[0] && !o_pwm.out[0])
        else $error("phase one not low in detection");
    a_sink_idle: assert property (!i_enable [*2] |=> o_test_sink_en == 3'h0)
        else $error("test sink on while disabled");
    a_unused_hiz: assert property (o_driver_on |-> o_pwm.oe == (4'hF >> (3'h4 - o_phase_count)))
        else $error("unused phase driven");
    a_ramp_gate: assert property (o_ramp_sense_en == i_enable)
        else $error("ramp input powered while disabled");
    a_ramp_step: assert property (o_driver_on |-> o_ramp_step == 2'(o_phase_count - 3'h1))
        else $error("ramp spacing wrong");
    a_high_trip: assert property (o_driver_on && i_enable && i_limit_over_high |-> ##[1:3] o_fault)
        else $error("high limit trip late");
    a_norm_early: assert property ($rose(o_fault) && !$past(i_limit_over_high)
        && !$past(i_limit_over_high, 2) |-> run_r >= OC_QUAL_CYCLES)
        else $error("normal limit tripped early");
    a_norm_trip: assert property (run_r == 16'(OC_QUAL_CYCLES + 6) |-> o_fault)
        else $error("normal limit did not trip");
    a_fault_latch: assert property (o_fault && i_enable |=> o_fault && !o_driver_on)
        else $error("fault released while enabled");
    a_addr_range: assert property (o_driver_on |-> o_bus_addr <= ADDR_MAX_CODE)
        else $error("address out of range");
endmodule
bind pdcl_phase_ctrl pdcl_chk u_pdcl_chk (
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_enable          (i_enable),
    .i_limit_over_norm (i_limit_over_norm),
    .i_limit_over_high (i_limit_over_high),
    .o_test_sink_en    (o_test_sink_en),
    .o_pwm             (o_pwm),
    .o_ramp_step       (o_ramp_step),
    .o_ramp_sense_en   (o_ramp_sense_en),
    .o_driver_on       (o_driver_on),
    .o_fault           (o_fault),
    .o_phase_count     (o_phase_count),
    .o_bus_addr        (o_bus_addr)
);

// ### test/pdcl_strap_model.sv
`timescale 1ns/10ps
module pdcl_strap_model
    import pdcl_pkg::*;
(
    input  wire logic [2:0] i_phases,
    input  wire logic [4:2] i_sink_en,
    output logic [4:2]      o_sense_high
);
    // ****************************************************************
    // Strap levels
    // ****************************************************************
    logic [4:2] tied;
    always_comb begin
        case (i_phases)
            PHASES_THREE: tied = 3'h4;
            PHASES_TWO:   tied = 3'h5;
            PHASES_ONE:   tied = 3'h7;
            default:      tied = 3'h0;
        endcase
        // Untied pins float high without the sink, so late sampling shows up.
        o_sense_high = tied | ~i_sink_en;
    end
endmodule

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import pdcl_pkg::*;
    logic i_clk, i_rst, i_enable, i_limit_over_norm, i_limit_over_high, i_ramp_uv;
    logic [4:2]       i_sense_high, o_test_sink_en;
    logic [3:0]       i_pwm_cmp, i_addr_strap, o_bus_addr, m;
    logic [ADC_W-1:0] i_current_max_strap_pin_adc, i_imon_adc, i_temp_adc;
    pdcl_rd_t         i_reg_rd;
    pdcl_pwm_t        o_pwm;
    logic [7:0]       o_reg_data;
    logic [1:0]       o_ramp_phase_sel, o_ramp_step;
    logic             o_ramp_sense_en, o_driver_on, o_fault;
    logic [2:0]       o_phase_count, ph;
    logic [15:0]      lf;
    int               err_total, compares, cyc, i, n;
    // ****************************************************************
    // Harness
    // ****************************************************************
    pdcl_phase_ctrl u_pdcl_phase_ctrl (
        .i_clk             (i_clk),
        .i_rst             (i_rst),
        .i_enable          (i_enable),
        .i_sense_high      (i_sense_high),
        .i_pwm_cmp         (i_pwm_cmp),
        .i_limit_over_norm (i_limit_over_norm),
        .i_limit_over_high (i_limit_over_high),
        .i_ramp_uv         (i_ramp_uv),
        .i_current_max_strap_pin_adc        (i_current_max_strap_pin_adc),
        .i_imon_adc        (i_imon_adc),
        .i_temp_adc        (i_temp_adc),
        .i_addr_strap      (i_addr_strap),
        .i_reg_rd          (i_reg_rd),
        .o_reg_data        (o_reg_data),
        .o_test_sink_en    (o_test_sink_en),
        .o_pwm             (o_pwm),
        .o_ramp_phase_sel  (o_ramp_phase_sel),
        .o_ramp_step       (o_ramp_step),
        .o_ramp_sense_en   (o_ramp_sense_en),
        .o_driver_on       (o_driver_on),
        .o_fault           (o_fault),
        .o_phase_count     (o_phase_count),
        .o_bus_addr        (o_bus_addr)
    );
    pdcl_strap_model u_pdcl_strap_model (.i_phases(ph), .i_sink_en(o_test_sink_en),
        .o_sense_high(i_sense_high));
    always #4 i_clk = ~i_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [7:0] sat(input logic [ADC_W-1:0] c);
        return (c >= 10'h100) ? 8'hFF : c[7:0];
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task step(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        i_reg_rd = '{addr: a, rd: 1'b1};
        step(1);
        i_reg_rd.rd = 1'b0;
        step(1);
        chk(o_reg_data, e);
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        {i_clk, i_enable, i_limit_over_norm, i_limit_over_high, i_ramp_uv} = '0;
        {i_pwm_cmp, i_addr_strap, i_current_max_strap_pin_adc, i_imon_adc, i_temp_adc} = '0;
        i_reg_rd = '0;
        ph = PHASES_FOUR;
        lf = 16'h003E;
        i_rst = 1'b1;
        step(2);
        i_rst = 1'b0;
        chk(o_phase_count, PHASES_FOUR);
        for (i = 0; i < 5; i++) begin
            ph = (i == 4) ? PHASES_FOUR : 3'(4 - i);
            m = 4'hF >> (3'h4 - ph);
            lf = lfsr(lf);
            i_addr_strap = (i == 0) ? 4'h8 : lf[3:0];
            i_current_max_strap_pin_adc = (i == 0) ? 10'h100 : lf[15:6];
            i_imon_adc = lf[9:0];
            i_temp_adc = {lf[4:0], lf[15:11]};
            i_enable = 1'b1;
            step(10);
            chk(o_test_sink_en, 3'h7);
            chk({o_pwm.oe[0], o_pwm.out[0]}, 2'b10);
            step(3700);
            chk(o_driver_on, 1'b0);
            n = 0;
            while (o_driver_on !== 1'b1 && n < 100) begin
                step(1);
                n++;
            end
            chk(o_test_sink_en, 3'h0);
            chk(o_phase_count, ph);
            chk(o_pwm.oe, m);
            chk(o_pwm.mid, m);
            chk(o_ramp_phase_sel, 2'(ph - 3'h1));
            chk(o_bus_addr, (i_addr_strap > 4'h8) ? 4'h8 : i_addr_strap);
            i_current_max_strap_pin_adc = ~i_current_max_strap_pin_adc;
            rd(PLAT_CUR_MAX_OFFSET, sat(~i_current_max_strap_pin_adc));
            rd(CURRENT_OFFSET, sat(i_imon_adc));
            rd(TEMP_OFFSET, sat(i_temp_adc));
            rd(8'h30, 8'h00);
            rd(ADDR_OFFSET, {4'h0, (i_addr_strap > 4'h8) ? 4'h8 : i_addr_strap});
            rd(STATUS_OFFSET, {5'h00, ph});
            i_pwm_cmp = 4'hF;
            step(1);
            chk(o_pwm.out & o_pwm.oe, m);
            chk(o_pwm.mid, 4'h0);
            i_pwm_cmp = lf[7:4];
            step(3);
            chk(o_pwm.out & o_pwm.oe, lf[7:4] & m);
            if (i == 4) begin
                i_ramp_uv = 1'b1;
                step(3);
                chk(o_driver_on, 1'b0);
                i_ramp_uv = 1'b0;
            end else if (i[0]) begin
                i_limit_over_norm = 1'b1;
                step(3000);
                i_limit_over_norm = 1'b0;
                step(2);
                i_limit_over_norm = 1'b1;
                step(6000);
                chk(o_fault, 1'b0);
                step(300);
                chk(o_fault, 1'b1);
                i_limit_over_norm = 1'b0;
            end else begin
                i_limit_over_high = 1'b1;
                step(3);
                chk(o_fault, 1'b1);
                i_limit_over_high = 1'b0;
            end
            step(20);
            chk({o_fault, o_driver_on}, (i == 4) ? 2'b00 : 2'b10);
            rd(STATUS_OFFSET, {3'h0, i != 4, 1'b0, ph});
            i_enable = 1'b0;
            i_pwm_cmp = 4'h0;
            step(3);
            chk({o_fault, o_ramp_sense_en}, 2'b00);
        end
        print_verdict();
    end
endmodule
